// file: pkg/spl_pkg.sv
// Notes on behaviour
// - baud code 6 gives 300 bits per second
// - reset: 8 data, no parity, 1 stop, flow
// - word format 2 gives 7 data, parity only with parity code 2 or 6
// - parity code 6 even, code 2 odd
// - listener bytes leave on serial line in order
// - stop on XOFF, resume on XON
// - drive printer DSR before sending characters
// - drive printer CTS before expecting characters
// - drive line detect while line is valid
// - CTS held until printer drops RTS first
package spl_pkg;
   localparam int MCLK_HZ = 100_000_000;
   // register offsets
   localparam logic [3:0] ADR_FMT = 4'h6;
   localparam logic [3:0] ADR_BAUD = 4'h7;
   localparam logic [3:0] ADR_PAR = 4'h8;
   localparam logic [3:0] ADR_CTL = 4'hA;
   localparam logic [3:0] ADR_STAT = 4'hB;
   localparam logic [3:0] ADR_RXD = 4'hC;
   // setting codes
   localparam logic [3:0] FMT_8N = 4'h0;
   localparam logic [3:0] FMT_7P = 4'h2;
   localparam logic [3:0] PAR_NONE = 4'h0;
   localparam logic [3:0] PAR_ODD = 4'h2;
   localparam logic [3:0] PAR_EVEN = 4'h6;
   localparam logic [3:0] BAUD_110 = 4'h4;
   localparam logic [3:0] BAUD_150 = 4'h5;
   localparam logic [3:0] BAUD_300 = 4'h6;
   localparam logic [3:0] BAUD_600 = 4'h7;
   localparam logic [3:0] BAUD_1200 = 4'h8;
   localparam logic [3:0] BAUD_2400 = 4'h9;
   localparam logic [3:0] BAUD_4800 = 4'hA;
   localparam logic [3:0] BAUD_9600 = 4'hB;
   // line rates in bits per second
   localparam int BPS_110 = 110;
   localparam int BPS_150 = 150;
   localparam int BPS_300 = 300;
   localparam int BPS_600 = 600;
   localparam int BPS_1200 = 1200;
   localparam int BPS_2400 = 2400;
   localparam int BPS_4800 = 4800;
   localparam int BPS_9600 = 9600;
   // field positions
   localparam int FMT_STOP2 = 3;
   localparam int CTL_EN = 0;
   localparam int CTL_FLOW = 1;
   // reset values
   localparam logic [3:0] RST_FMT = FMT_8N;
   localparam logic [3:0] RST_BAUD = BAUD_9600;
   localparam logic [3:0] RST_PAR = PAR_NONE;
   localparam logic [1:0] RST_CTL = 2'h3;
   // flow control characters
   localparam logic [7:0] CHR_XON = 8'h11;
   localparam logic [7:0] CHR_XOFF = 8'h13;
   localparam int FIFO_W = 8;
   localparam int FIFO_D = 32;

   typedef enum logic [0:0] {T_IDLE = 1'b0, T_BIT = 1'b1} spl_tx_st_t;
   typedef enum logic [1:0] {R_IDLE = 2'b00, R_START = 2'b01, R_DATA = 2'b10,
      R_STOP = 2'b11} spl_rx_st_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } spl_bus_t;

   typedef struct packed {
      logic [3:0] fmt;
      logic [3:0] baud;
      logic [3:0] par;
      logic [1:0] ctl;
      spl_tx_st_t tst;
      logic [3:0] tcnt;
      logic [10:0] tsh;
      logic txd;
      spl_rx_st_t rst;
      logic [3:0] rcnt;
      logic [8:0] rsh;
      logic [7:0] rdat;
      logic rvld;
      logic err;
      logic xoff;
      logic dsr;
      logic cts;
      logic dcd;
      logic [7:0] rdata;
   } spl_st_t;
endpackage

// file: src/spl_bit_timer.sv
`timescale 1ns/10ps
module spl_bit_timer (
   input wire logic mclk,
   input wire logic rst,
   input wire logic load,
   input wire logic [23:0] len,
   output logic done
);
   typedef struct packed {
      logic [23:0] cnt;
   } spl_tmr_t;
   spl_tmr_t st_r, st_nxt;

   // count down; done marks the last cycle of the period
   always_comb
   begin
      st_nxt = st_r;
      if (load)
         st_nxt.cnt = len;
      else if (st_r.cnt != 24'h000000)
         st_nxt.cnt = st_r.cnt - 24'h000001;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign done = (st_r.cnt == 24'h000001);
endmodule

// file: src/spl_fifo.sv
`timescale 1ns/10ps
module spl_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } spl_fst_t;
   spl_fst_t st_r, st_nxt;
   logic [W-1:0] mem [D];
   logic push, pop;

   // ready is registered so the top drives it straight from a flop
   always_comb
   begin
      st_nxt = st_r;
      push = in_valid && st_r.rdy;
      pop = out_ready && (st_r.cnt != '0);
      if (push)
         st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : st_r.wp + 1'b1;
      if (pop)
         st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : st_r.rp + 1'b1;
      if (push && !pop)
         st_nxt.cnt = st_r.cnt + 1'b1;
      else if (pop && !push)
         st_nxt.cnt = st_r.cnt - 1'b1;
      st_nxt.rdy = (st_nxt.cnt != (AW + 1)'(D));
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= '0;
         st_r.rdy <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   // storage has no reset; only written words are ever read
   always_ff @(posedge mclk)
   begin
      if (push)
         mem[st_r.wp] <= in_data;
   end

   assign in_ready = st_r.rdy;
   assign out_valid = (st_r.cnt != '0);
   assign out_data = mem[st_r.rp];
endmodule

// file: src/spl_port.sv
`timescale 1ns/10ps
module spl_port #(
   parameter int CLK_HZ = spl_pkg::MCLK_HZ
) (
   input wire logic mclk,
   input wire logic rst,
   input wire spl_pkg::spl_bus_t bus,
   output logic [7:0] rd_data,
   input wire logic [7:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic txd,
   input wire logic rxd,
   input wire logic rts_i,
   input wire logic dtr_i,
   output logic dsr_o,
   output logic cts_o,
   output logic dcd_o
);
   import spl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bit periods in mclk cycles
   localparam logic [23:0] CNT_110 = 24'(CLK_HZ / BPS_110);
   localparam logic [23:0] CNT_150 = 24'(CLK_HZ / BPS_150);
   localparam logic [23:0] CNT_300 = 24'(CLK_HZ / BPS_300);
   localparam logic [23:0] CNT_600 = 24'(CLK_HZ / BPS_600);
   localparam logic [23:0] CNT_1200 = 24'(CLK_HZ / BPS_1200);
   localparam logic [23:0] CNT_2400 = 24'(CLK_HZ / BPS_2400);
   localparam logic [23:0] CNT_4800 = 24'(CLK_HZ / BPS_4800);
   localparam logic [23:0] CNT_9600 = 24'(CLK_HZ / BPS_9600);

   spl_st_t st_r, st_nxt;
   logic [7:0] f_dout;
   logic f_valid, f_pop;
   logic t_load, t_done, r_load, r_done;
   logic [23:0] blen, r_len;
   logic tx_go, send_ok;
   logic [3:0] nd, np, ns, tot, rn;
   logic [7:0] data_m, rbyte;
   logic [11:0] frame;
   logic par_bit, rpar, rx_ok;
   logic [8:0] rword;

   // unknown codes fall back to the fastest rate
   function automatic logic [23:0] bit_len(input logic [3:0] code);
      case (code)
         BAUD_110: bit_len = CNT_110;
         BAUD_150: bit_len = CNT_150;
         BAUD_300: bit_len = CNT_300;
         BAUD_600: bit_len = CNT_600;
         BAUD_1200: bit_len = CNT_1200;
         BAUD_2400: bit_len = CNT_2400;
         BAUD_4800: bit_len = CNT_4800;
         default: bit_len = CNT_9600;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // listener bytes queue here so the host side sees back-pressure
   spl_fifo #(.W(FIFO_W), .D(FIFO_D)) u_txq (
      .mclk(mclk),
      .rst(rst),
      .in_data(in_data),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .out_data(f_dout),
      .out_valid(f_valid),
      .out_ready(f_pop)
   );

   spl_bit_timer u_ttmr (
      .mclk(mclk),
      .rst(rst),
      .load(t_load),
      .len(blen),
      .done(t_done)
   );

   spl_bit_timer u_rtmr (
      .mclk(mclk),
      .rst(rst),
      .load(r_load),
      .len(r_len),
      .done(r_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // character shape from the three settings
   always_comb
   begin
      blen = bit_len(st_r.baud);
      nd = (st_r.fmt == FMT_7P) ? 4'h7 : 4'h8;
      np = (st_r.par == PAR_EVEN || st_r.par == PAR_ODD) ? 4'h1 : 4'h0;
      ns = st_r.fmt[FMT_STOP2] ? 4'h2 : 4'h1;
      tot = 4'h1 + nd + np + ns;
      rn = nd + np;
      data_m = (nd == 4'h7) ? {1'b0, f_dout[6:0]} : f_dout;
      par_bit = (st_r.par == PAR_ODD) ? ~^data_m : ^data_m;
      // start low, data lsb first, parity, stop bits high
      frame = 12'hFFF;
      frame[0] = 1'b0;
      frame[8:1] = data_m;
      if (nd == 4'h7)
         frame[8] = 1'b1;
      if (np != 4'h0)
         frame[nd + 4'h1] = par_bit;
   end

   // received word sits at the top of the shifter; realign it
   always_comb
   begin
      rword = st_r.rsh >> (4'h9 - rn);
      rbyte = (nd == 4'h7) ? {1'b0, rword[6:0]} : rword[7:0];
      rpar = rword[nd];
      rx_ok = rxd;
      if (np != 4'h0)
         rx_ok = rxd && ((st_r.par == PAR_ODD) == (^rbyte ^ rpar));
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers, control lines and both framers
   always_comb
   begin
      st_nxt = st_r;
      f_pop = 1'b0;
      t_load = 1'b0;
      r_load = 1'b0;
      r_len = blen;
      tx_go = 1'b0;
      // register writes
      if (bus.wr)
      begin
         case (bus.addr)
            ADR_FMT: st_nxt.fmt = bus.wdata[3:0];
            ADR_BAUD: st_nxt.baud = bus.wdata[3:0];
            ADR_PAR: st_nxt.par = bus.wdata[3:0];
            ADR_CTL: st_nxt.ctl = bus.wdata[1:0];
            default: st_nxt.ctl = st_r.ctl;
         endcase
      end
      // reads; clears come first so a same-cycle set wins
      st_nxt.rdata = 8'h00;
      if (bus.rd)
      begin
         case (bus.addr)
            ADR_FMT: st_nxt.rdata = {4'h0, st_r.fmt};
            ADR_BAUD: st_nxt.rdata = {4'h0, st_r.baud};
            ADR_PAR: st_nxt.rdata = {4'h0, st_r.par};
            ADR_CTL: st_nxt.rdata = {6'h00, st_r.ctl};
            ADR_STAT:
            begin
               st_nxt.rdata = {1'b0, rts_i, dtr_i, ~in_ready, f_valid,
                  st_r.xoff, st_r.err, st_r.rvld};
               st_nxt.err = 1'b0;
            end
            ADR_RXD:
            begin
               st_nxt.rdata = st_r.rdat;
               st_nxt.rvld = 1'b0;
            end
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      // modem lines toward the printer
      st_nxt.dsr = st_r.ctl[CTL_EN];
      // cts only drops once the printer has dropped rts
      st_nxt.cts = st_r.ctl[CTL_EN] | (st_r.cts & rts_i);
      // printer dtr gates the start of each byte, along with dsr, dcd and xoff
      send_ok = st_r.dsr && st_r.dcd && dtr_i
         && !(st_r.ctl[CTL_FLOW] && st_r.xoff);
      // transmitter
      case (st_r.tst)
         T_IDLE:
         begin
            if (f_valid && send_ok)
            begin
               tx_go = 1'b1;
               f_pop = 1'b1;
               st_nxt.txd = frame[0];
               st_nxt.tsh = frame[11:1];
               st_nxt.tcnt = tot - 4'h1;
               t_load = 1'b1;
               st_nxt.tst = T_BIT;
            end
         end
         T_BIT:
         begin
            if (t_done)
            begin
               if (st_r.tcnt == 4'h0)
                  st_nxt.tst = T_IDLE;
               else
               begin
                  st_nxt.txd = st_r.tsh[0];
                  st_nxt.tsh = {1'b1, st_r.tsh[10:1]};
                  st_nxt.tcnt = st_r.tcnt - 4'h1;
                  t_load = 1'b1;
               end
            end
         end
         default: st_nxt.tst = T_IDLE;
      endcase
      // line detect also covers the tail of a frame already on the wire,
      // so disabling the port mid-character never cuts the signal short
      st_nxt.dcd = st_r.ctl[CTL_EN] | (st_nxt.tst == T_BIT);
      // receiver; only listens once cts is given
      case (st_r.rst)
         R_IDLE:
         begin
            if (st_r.cts && !rxd)
            begin
               r_len = {1'b0, blen[23:1]};
               r_load = 1'b1;
               st_nxt.rst = R_START;
            end
         end
         R_START:
         begin
            if (r_done)
            begin
               if (!rxd)
               begin
                  r_load = 1'b1;
                  st_nxt.rcnt = rn - 4'h1;
                  st_nxt.rst = R_DATA;
               end
               else
                  st_nxt.rst = R_IDLE;
            end
         end
         R_DATA:
         begin
            if (r_done)
            begin
               st_nxt.rsh = {rxd, st_r.rsh[8:1]};
               r_load = 1'b1;
               if (st_r.rcnt == 4'h0)
                  st_nxt.rst = R_STOP;
               else
                  st_nxt.rcnt = st_r.rcnt - 4'h1;
            end
         end
         R_STOP:
         begin
            if (r_done)
            begin
               st_nxt.rst = R_IDLE;
               if (!rx_ok)
                  st_nxt.err = 1'b1;
               else if (st_r.ctl[CTL_FLOW] && rbyte == CHR_XOFF)
                  st_nxt.xoff = 1'b1;
               else if (st_r.ctl[CTL_FLOW] && rbyte == CHR_XON)
                  st_nxt.xoff = 1'b0;
               else
               begin
                  st_nxt.rdat = rbyte;
                  st_nxt.rvld = 1'b1;
               end
            end
         end
         default: st_nxt.rst = R_IDLE;
      endcase
   end

   // defaults: 8 data, no parity, 1 stop, port on, flow on
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= '0;
         st_r.fmt <= RST_FMT;
         st_r.baud <= RST_BAUD;
         st_r.par <= RST_PAR;
         st_r.ctl <= RST_CTL;
         st_r.txd <= 1'b1;
         st_r.tsh <= 11'h7FF;
      end
      else
         st_r <= st_nxt;
   end

   assign rd_data = st_r.rdata;
   assign txd = st_r.txd;
   assign dsr_o = st_r.dsr;
   assign cts_o = st_r.cts;
   assign dcd_o = st_r.dcd;

   ////////////////////////////////////////////////////////////////////////////
   // checks on the framing and line control
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence seq_tx_go;
      st_r.tst == T_IDLE && tx_go;
   endsequence

   sequence seq_rx_begin;
      st_r.rst == R_IDLE ##1 st_r.rst == R_START;
   endsequence

   // a good pacing character closing its stop bit
   sequence seq_rx_flow;
      st_r.rst == R_STOP && r_done && rx_ok && st_r.ctl[CTL_FLOW]
         && (rbyte == CHR_XOFF || rbyte == CHR_XON);
   endsequence

   AST_BAUD300: assert property (
      (st_r.baud == BAUD_300) |-> (blen == CNT_300))
      else $error("bit period wrong at 300 baud");
   AST_RST_DEFAULT: assert property (
      $past(rst) |-> (st_r.fmt == FMT_8N && st_r.par == PAR_NONE && st_r.ctl[CTL_FLOW]))
      else $error("reset framing not 8N1 with flow");
   AST_SEVEN: assert property (
      (seq_tx_go and (st_r.fmt == FMT_7P && (st_r.par == PAR_EVEN || st_r.par == PAR_ODD)))
      |=> st_r.tcnt == 4'h9)
      else $error("seven bit frame has wrong length");
   AST_EVEN: assert property (
      (seq_tx_go and (st_r.fmt == FMT_7P && st_r.par == PAR_EVEN))
      |=> st_r.tsh[7] == ^$past(f_dout[6:0]))
      else $error("even parity bit wrong");
   AST_ODD: assert property (
      (seq_tx_go and (st_r.fmt == FMT_7P && st_r.par == PAR_ODD))
      |=> st_r.tsh[7] == ~^$past(f_dout[6:0]))
      else $error("odd parity bit wrong");
   AST_ORDER: assert property (
      seq_tx_go |-> f_pop ##1 (st_r.tst == T_BIT && !txd))
      else $error("byte not popped into a start bit");
   AST_XOFF: assert property (
      (st_r.ctl[CTL_FLOW] && st_r.xoff) |-> !tx_go)
      else $error("sent while paused by xoff");
   AST_FLOW_EAT: assert property (
      seq_rx_flow |=> (!$rose(st_r.rvld) && $stable(st_r.rdat)))
      else $error("pacing character stored as data");
   AST_DSR: assert property (
      seq_tx_go |-> (dsr_o && dcd_o))
      else $error("sent without dsr");
   AST_CTS_RX: assert property (
      seq_rx_begin |-> $past(cts_o))
      else $error("receive started without cts");
   AST_DCD: assert property (
      (st_r.tst == T_BIT) |-> dcd_o)
      else $error("line detect low while sending");
   AST_CTS_HOLD: assert property (
      (cts_o && rts_i) |=> cts_o)
      else $error("cts dropped before rts");
   AST_STOP: assert property (
      (st_r.tst == T_BIT && st_r.tcnt == 4'h0) |-> txd[*2])
      else $error("stop bit not high");
endmodule

// file: test/spl_printer.sv
`timescale 1ns/10ps
module spl_printer (
   input wire logic mclk,
   input wire logic power,
   input wire logic [7:0] period,
   input wire logic [3:0] nbits,
   input wire logic txd,
   output logic rxd,
   output logic rts_i,
   output logic dtr_i,
   input wire logic dsr_o,
   input wire logic cts_o,
   input wire logic dcd_o
);
   logic [9:0] rxq[$];
   logic [7:0] low_run = 8'h00;
   logic [7:0] low_cnt = 8'h00;
   logic [9:0] w;
   int i;
   ////////////////////////////////////////////////////////////////
   // lines follow power only, never used for pacing
   assign rts_i = power;
   assign dtr_i = power;
   initial rxd = 1'b1;
   // length of each low stretch, lets the bench see the bit period
   always @(posedge mclk)
   begin
      if (txd === 1'b0)
         low_cnt <= low_cnt + 8'h01;
      else if (low_cnt != 8'h00)
      begin
         low_run <= low_cnt;
         low_cnt <= 8'h00;
      end
   end
   // mid-bit sampler on falling edges, clear of the edges that move txd;
   // frames count only while the port gives its lines
   always
   begin
      @(negedge mclk);
      if (txd === 1'b0)
      begin
         w = 10'h000;
         repeat (period / 2) @(negedge mclk);
         for (i = 0; i < nbits; i++)
         begin
            repeat (period) @(negedge mclk);
            w[i] = txd;
         end
         repeat (period) @(negedge mclk);
         w[9] = txd;
         if (dsr_o && dcd_o)
            rxq.push_back(w);
      end
   end
   ////////////////////////////////////////////////////////////////
   // one 8N1 frame, held back until both go-ahead lines are up
   task automatic send(input logic [7:0] d);
      int k;
      wait (dsr_o === 1'b1 && cts_o === 1'b1);
      for (k = -1; k <= 8; k++)
      begin
         @(posedge mclk);
         rxd <= (k < 0) ? 1'b0 : (k > 7) ? 1'b1 : d[k];
         repeat (period - 1) @(posedge mclk);
      end
   endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import spl_pkg::*;
   // shortened clock so that a bit lasts tens of cycles, not thousands
   localparam int HZ = 9600;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   spl_bus_t bus = '0;
   logic [7:0] rd_data;
   logic [7:0] in_data = 8'h00;
   logic in_valid = 1'b0;
   logic in_ready;
   logic txd;
   logic rxd;
   logic rts_i;
   logic dtr_i;
   logic dsr_o;
   logic cts_o;
   logic dcd_o;
   logic power = 1'b1;
   logic [7:0] period = 8'h20;
   logic [3:0] nbits = 4'h8;
   logic [3:0] p;
   int failures = 0;
   int n_compared = 0;
   int j;
   int rate[7] = '{BPS_110, BPS_150, BPS_300, BPS_600, BPS_1200, BPS_2400, BPS_4800};
   ////////////////////////////////////////////////////////////////
   spl_port #(.CLK_HZ(HZ)) spl_port_i (.mclk(mclk), .rst(rst), .bus(bus), .rd_data(rd_data),
      .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .txd(txd), .rxd(rxd),
      .rts_i(rts_i), .dtr_i(dtr_i), .dsr_o(dsr_o), .cts_o(cts_o), .dcd_o(dcd_o));
   spl_printer spl_printer_i (.mclk(mclk), .power(power), .period(period), .nbits(nbits),
      .txd(txd), .rxd(rxd), .rts_i(rts_i), .dtr_i(dtr_i), .dsr_o(dsr_o), .cts_o(cts_o),
      .dcd_o(dcd_o));
   always #5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("BAD at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   // read, compare masked data, then see the data drop back to zero
   task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      @(negedge mclk);
      chk({2'h0, rd_data & m}, {2'h0, e});
      @(negedge mclk);
      chk({2'h0, rd_data}, 10'h000);
   endtask
   // offers one byte and holds it until the buffer takes it
   task automatic push(input logic [7:0] d);
      int k = 0;
      @(posedge mclk);
      in_data <= d;
      in_valid <= 1'b1;
      @(negedge mclk);
      while (in_ready !== 1'b1 && k < 20000)
      begin
         @(negedge mclk);
         k++;
      end
      // a buffer that never makes room counts against the run
      if (k >= 20000)
         failures++;
      @(posedge mclk);
      in_valid <= 1'b0;
   endtask
   // a frame that never shows up compares as the inverse
   task automatic expect_frame(input logic [9:0] e);
      int k = 0;
      logic [9:0] g;
      while (spl_printer_i.rxq.size() == 0 && k < 3000)
      begin
         @(posedge mclk);
         k++;
      end
      g = (spl_printer_i.rxq.size() > 0) ? spl_printer_i.rxq.pop_front() : ~e;
      chk(g, e);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // watchdog well beyond the roughly 14k cycles the tests need
   initial
   begin
      #600_000;
      failures++;
      final_report;
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({6'h0, dsr_o, cts_o, dcd_o, txd}, 10'h00F);
      rchk(ADR_FMT, 8'hFF, {4'h0, RST_FMT});
      rchk(ADR_BAUD, 8'hFF, {4'h0, RST_BAUD});
      rchk(ADR_PAR, 8'hFF, {4'h0, RST_PAR});
      rchk(ADR_CTL, 8'hFF, {6'h0, RST_CTL});
      rchk(4'hF, 8'hFF, 8'h00);
      rchk(ADR_STAT, 8'h7F, 8'h60);
      $display("test reset done");
      // every rate code from 110 to 4800, bit length read off the line
      for (j = 0; j < 7; j++)
      begin
         period <= 8'(HZ / rate[j]);
         wr(ADR_BAUD, {4'h0, BAUD_110 + 4'(j)});
         push(8'h55);
         expect_frame(10'h255);
         chk({2'h0, spl_printer_i.low_run}, {2'h0, period});
      end
      $display("test rates done");
      wr(ADR_BAUD, {4'h0, BAUD_300});
      period <= 8'h20;
      wr(ADR_FMT, {4'h0, FMT_7P});
      for (j = 0; j < 2; j++)
      begin
         p = (j == 0) ? PAR_EVEN : PAR_ODD;
         wr(ADR_PAR, {4'h0, p});
         push(8'hD3);
         expect_frame({2'b10, (^7'h53) ^ j[0], 7'h53});
      end
      wr(ADR_FMT, {4'h0, FMT_8N});
      wr(ADR_PAR, {4'h0, PAR_NONE});
      $display("test parity done");
      // byte from the printer lands in the receive register
      spl_printer_i.send(8'h41);
      repeat (40) @(posedge mclk);
      rchk(ADR_STAT, 8'h01, 8'h01);
      rchk(ADR_RXD, 8'hFF, 8'h41);
      rchk(ADR_STAT, 8'h01, 8'h00);
      $display("test receive done");
      // pause, fill the buffer to refusal, then resume and drain
      spl_printer_i.send(CHR_XOFF);
      repeat (40) @(posedge mclk);
      rchk(ADR_STAT, 8'h05, 8'h04);
      for (j = 0; j < 32; j++)
         push(8'h20 + 8'(j));
      @(negedge mclk);
      chk({9'h0, in_ready}, 10'h000);
      rchk(ADR_STAT, 8'h18, 8'h18);
      chk(10'(spl_printer_i.rxq.size()), 10'h000);
      spl_printer_i.send(CHR_XON);
      for (j = 0; j < 32; j++)
         expect_frame({2'b10, 8'h20 + 8'(j)});
      rchk(ADR_STAT, 8'h1C, 8'h00);
      $display("test flow done");
      // disabling keeps the go-ahead until the printer lets go first
      wr(ADR_CTL, 8'h00);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk({9'h0, cts_o}, 10'h001);
      power <= 1'b0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk({9'h0, cts_o}, 10'h000);
      rchk(ADR_STAT, 8'h60, 8'h00);
      $display("test handover done");
      final_report;
   end
endmodule
